//--- dv/pwr_seq_props.sv
// Purpose: Pin checks between the host end and the module end.
// Assumes: One core clock; counters span tens of milliseconds.
// Notes:   Sleep state is not on the pins, so the bench judges it.
`timescale 1ns/1ps
`default_nettype none
module pwr_seq_props #(
	parameter int unsigned MS_TICKS = pwr_seq_pkg::MS_CYCLES // Cycles per ms.
) (
	input wire logic i_core_clk,       // Core clock.
	input wire logic i_reset_n,        // Synchronous reset, active low.
	input wire logic power_key_n,      // Power key level.
	input wire logic fast_off_pin_oe,  // Host drive enable, fast-off.
	input wire logic fast_off_pin,     // Resolved fast-off pin.
	input wire logic status,           // Module status.
	input wire logic off_command,      // Power-off command strobe.
	input wire logic fast_cfg_command  // Fast-off configuration strobe.
);
	localparam logic [19:0] OFF_LATE  = 20'(70 * MS_TICKS); // Past shutdown.
	localparam logic [19:0] OFF_EARLY = 20'(40 * MS_TICKS); // Before it.
	localparam logic [19:0] FAST_LATE = 20'(60 * MS_TICKS); // After a fall.
	logic [19:0] off_cnt;      // Cycles since an accepted off command.
	logic [19:0] fast_cnt;     // Cycles since a fast-off fall.
	logic        armed;        // Fast shutdown configured this power-up.
	logic        fast_at_fall; // Armed state seen at the last fall.
	logic        pin_q;        // Fast-off pin one cycle back.
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_reset_n);
	// Long waits live in counters, since repetitions must stay short.
	always_ff @(posedge i_core_clk)
	begin
		if (!i_reset_n)
		begin
			off_cnt <= '0;
			fast_cnt <= '0;
			armed <= 1'b0;
			fast_at_fall <= 1'b0;
			pin_q <= 1'b1;
		end
		else
		begin
			pin_q <= fast_off_pin;
			// Configuration is forgotten whenever the module is down.
			armed <= status & (armed | fast_cfg_command);
			if (off_command && status)
				off_cnt <= 20'h1;
			else if (off_cnt == OFF_LATE)
				off_cnt <= '0;
			else if (off_cnt != '0)
				off_cnt <= off_cnt + 20'h1;
			if (pin_q && !fast_off_pin && status)
			begin
				fast_cnt <= 20'h1;
				fast_at_fall <= armed;
			end
			else if (fast_cnt == FAST_LATE)
				fast_cnt <= '0;
			else if (fast_cnt != '0)
				fast_cnt <= fast_cnt + 20'h1;
		end
	end
	property p_reset_quiet;
		$rose(i_reset_n) |-> !status;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("status high out of reset");
	property p_boot_release;
		$rose(status) |-> power_key_n && $past(power_key_n);
	endproperty
	a_boot_release: assert property (p_boot_release) else $error("status rose with key low");
	property p_pull_up;
		!fast_off_pin_oe |-> fast_off_pin;
	endproperty
	a_pull_up: assert property (p_pull_up) else $error("fast-off pin not pulled up");
	property p_off_orderly;
		off_cnt != '0 && off_cnt < OFF_EARLY |-> status;
	endproperty
	a_off_orderly: assert property (p_off_orderly) else $error("off command cut power early");
	property p_off_done;
		off_cnt == OFF_LATE |-> !status;
	endproperty
	a_off_done: assert property (p_off_done) else $error("off command did not shut down");
	property p_fast_armed;
		fast_cnt == FAST_LATE && fast_at_fall |-> !status;
	endproperty
	a_fast_armed: assert property (p_fast_armed) else $error("fast-off too slow");
	property p_fast_idle;
		fast_cnt == FAST_LATE && !fast_at_fall |-> status;
	endproperty
	a_fast_idle: assert property (p_fast_idle) else $error("unarmed fast-off acted");
	property p_off_strobe;
		off_command |=> !off_command;
	endproperty
	a_off_strobe: assert property (p_off_strobe) else $error("off strobe too long");
	property p_cfg_strobe;
		fast_cfg_command |=> !fast_cfg_command;
	endproperty
	a_cfg_strobe: assert property (p_cfg_strobe) else $error("config strobe too long");
endmodule : pwr_seq_props
`default_nettype wire

//--- dv/test_module_power_key_sequencer.sv
// Purpose: Drives the host end and watches both user sides.
// Assumes: Counts use a shortened millisecond of 10 cycles, so the run stays short.
// Notes:   Expected status edges are queued before each command.
`timescale 1ns/1ps
`default_nettype none
module test_module_power_key_sequencer;
	// A shortened millisecond keeps the run to tens of thousands of cycles.
	localparam int unsigned MS = 10;
	logic i_core_clk = 1'b0;   // Core clock, 100 ns period.
	logic i_reset_n;           // Reset, active low.
	logic i_tau_expire;        // Timer expiry pulse.
	logic i_enter_psm;         // Sleep request pulse.
	logic o_ready;             // Host idle.
	logic o_status;            // Synchronised status.
	logic o_deep_sleep;        // Module asleep.
	logic watch = 1'b0;        // Status edges are judged while high.
	logic last_status = 1'b0;  // Status one negedge back.
	logic exp_q[$];            // Expected status edges, oldest first.
	int errors = 0;            // Mismatch count.
	int n_tests = 0;           // Comparison count.
	int cnt;                   // Cycles waited for the host.
	pwr_seq_pkg::host_cmd_e i_cmd; // Host command.
	pwr_seq_if pins ();
	module_power_key_sequencer #(.MS_TICKS(MS))
		module_power_key_sequencer_inst (
		.i_core_clk(i_core_clk), .i_reset_n(i_reset_n),
		.i_tau_expire(i_tau_expire), .i_enter_psm(i_enter_psm),
		.o_deep_sleep(o_deep_sleep), .pins(pins));
	power_key_host #(.MS_TICKS(MS)) power_key_host_inst (
		.i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_cmd(i_cmd),
		.o_ready(o_ready), .o_status(o_status), .pins(pins));
	pwr_seq_props #(.MS_TICKS(MS)) pwr_seq_props_inst (
		.i_core_clk(i_core_clk), .i_reset_n(i_reset_n),
		.power_key_n(pins.power_key_n),
		.fast_off_pin_oe(pins.fast_off_pin_oe),
		.fast_off_pin(pins.fast_off_pin), .status(pins.status),
		.off_command(pins.off_command),
		.fast_cfg_command(pins.fast_cfg_command));
	always #50 i_core_clk = ~i_core_clk;
	task check(input logic got, input logic exp);
		n_tests++;
		if (got !== exp)
		begin
			errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	task complete_run;
		$display("comparisons=%0d mismatches=%0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : complete_run
	// Bounded wait for the host to go idle; a hang ends the run.
	task wait_ready;
		cnt = 0;
		while (o_ready !== 1'b1 && cnt < 4000 * MS)
		begin
			@(negedge i_core_clk);
			cnt++;
		end
		if (o_ready !== 1'b1)
		begin
			errors++;
			complete_run();
		end
	endtask : wait_ready
	// The command is held one cycle while the host is idle.
	task issue(input pwr_seq_pkg::host_cmd_e c);
		wait_ready();
		i_cmd = c;
		@(negedge i_core_clk);
		i_cmd = pwr_seq_pkg::CMD_NONE;
		@(negedge i_core_clk);
		wait_ready();
	endtask : issue
	// A random idle gap lets status settle, then all edges must be seen.
	task end_test(input string name);
		repeat ((100 + $urandom % 50) * MS) @(negedge i_core_clk);
		check(exp_q.size() == 0, 1'b1);
		$display("test %s done", name);
	endtask : end_test
	task pulse(input logic tau);
		i_tau_expire = tau;
		i_enter_psm = !tau;
		// A random hold length shows that a long request acts only once.
		repeat (1 + $urandom % 4) @(negedge i_core_clk);
		i_tau_expire = 1'b0;
		i_enter_psm = 1'b0;
		repeat (10) @(negedge i_core_clk);
	endtask : pulse
	// Any status change while watch is high is matched against the oldest expectation.
	always @(negedge i_core_clk)
	begin
		if (watch && o_status !== last_status)
			check(o_status, exp_q.size() ? exp_q.pop_front() : last_status);
		last_status <= o_status;
	end
	initial
	begin
		i_reset_n = 1'b0;
		i_tau_expire = 1'b0;
		i_enter_psm = 1'b0;
		i_cmd = pwr_seq_pkg::CMD_NONE;
		void'($urandom(32'h14544d1a));
		repeat (12) @(negedge i_core_clk);
		i_reset_n = 1'b1;
		wait_ready();
		check(cnt >= 30 * MS, 1'b1);
		check(pins.psm_wake_pin, 1'b0);
		watch = 1'b1;
		exp_q.push_back(1'b1);
		issue(pwr_seq_pkg::CMD_POWER_ON);
		end_test("power_on");
		exp_q.push_back(1'b0);
		issue(pwr_seq_pkg::CMD_OFF_COMMAND);
		check(pins.power_key_n, 1'b1);
		end_test("off_command");
		exp_q.push_back(1'b1);
		issue(pwr_seq_pkg::CMD_POWER_ON);
		// Let status rise first, so the unarmed fall is judged by the checker.
		repeat (5 * MS) @(negedge i_core_clk);
		issue(pwr_seq_pkg::CMD_FAST_OFF);
		end_test("fast_off_unarmed");
		issue(pwr_seq_pkg::CMD_FAST_CFG);
		exp_q.push_back(1'b0);
		issue(pwr_seq_pkg::CMD_FAST_OFF);
		end_test("fast_off_armed");
		exp_q.push_back(1'b1);
		issue(pwr_seq_pkg::CMD_POWER_ON);
		end_test("power_on_again");
		watch = 1'b0;
		pulse(1'b0);
		check(o_deep_sleep, 1'b1);
		issue(pwr_seq_pkg::CMD_WAKE);
		repeat (10) @(negedge i_core_clk);
		check(o_deep_sleep, 1'b0);
		pulse(1'b0);
		check(o_deep_sleep, 1'b1);
		pulse(1'b1);
		check(o_deep_sleep, 1'b0);
		repeat (100 * MS) @(negedge i_core_clk);
		watch = 1'b1;
		$display("test deep_sleep done");
		// A long press drops status, then the still-low key boots it again.
		exp_q.push_back(1'b0);
		exp_q.push_back(1'b1);
		issue(pwr_seq_pkg::CMD_RESET);
		end_test("reset");
		exp_q.push_back(1'b0);
		issue(pwr_seq_pkg::CMD_POWER_OFF);
		end_test("key_off");
		// Supply may only be cut once status shows the module is down.
		check(o_status, 1'b0);
		complete_run();
	end
endmodule : test_module_power_key_sequencer
`default_nettype wire

//--- rtl/module_power_key_sequencer.sv
// Purpose: Module end: power state sequencing from the control pins.
// Assumes: Key, fast-off and wake pins arrive asynchronously and are synchronised here; strobes are not.
// Notes:   Shutdown and boot lengths are plain parameters of this model.
// Notes on behaviour
// [RULE1] Host key low 500-1000 ms switches on.
// [RULE2] Host waits 30 ms after supply.
// [RULE3] Host never holds key low forever.
// [RULE4] Key low 650-1500 ms, release, shuts down.
// [RULE5] Power-off command shuts down like key.
// [RULE6] Host keeps key high after command.
// [RULE7] Host removes supply only after shutdown.
// [RULE8] Host judges shutdown from status level.
// [RULE9] Enabled fast-off edge powers off within 100ms.
// [RULE10] Fast shutdown disabled until configuration command.
// [RULE11] Fast-off pulled up, falling edge only.
// [RULE12] Restart low 2-3.8 s resets module.
// [RULE13] Wake rising edge held 30 ms exits sleep.
// [RULE14] Wake pin pulled down, rising edge only. The interface has no pull here; the host always drives the wake pin.
// [RULE15] Key low or timer expiry also wakes.
// [RULE16] Status high once powered up.
// [RULE17] Host times pulses with ms counter.
`timescale 1ns/1ps
`default_nettype none
module module_power_key_sequencer #(
	// Cycles per millisecond tick; a bench may shorten it to save run time.
	parameter int unsigned MS_TICKS = pwr_seq_pkg::MS_CYCLES
) (
	input  wire logic  i_core_clk,   // Core clock.
	input  wire logic  i_reset_n,    // Synchronous reset, active low.
	input  wire logic  i_tau_expire, // Tracking-area timer expiry pulse.
	input  wire logic  i_enter_psm,  // Request to enter deep sleep.
	output logic       o_deep_sleep, // High while in deep sleep.
	pwr_seq_if.device  pins          // Control pins toward the host.
);
	typedef enum logic [2:0] {
		ST_OFF, ST_BOOT, ST_ON, ST_SLEEP, ST_SHUTDOWN
	} mod_state_e;

	localparam logic [pwr_seq_pkg::MS_W-1:0] ON_MIN =
		pwr_seq_pkg::MS_W'(pwr_seq_pkg::ON_MIN_MS);
	localparam logic [pwr_seq_pkg::MS_W-1:0] OFF_MIN =
		pwr_seq_pkg::MS_W'(pwr_seq_pkg::OFF_MIN_MS);
	localparam logic [pwr_seq_pkg::MS_W-1:0] OFF_MAX =
		pwr_seq_pkg::MS_W'(pwr_seq_pkg::OFF_MAX_MS);
	localparam logic [pwr_seq_pkg::MS_W-1:0] RST_MIN =
		pwr_seq_pkg::MS_W'(pwr_seq_pkg::RST_MIN_MS);
	localparam logic [pwr_seq_pkg::MS_W-1:0] WAKE_MIN =
		pwr_seq_pkg::MS_W'(pwr_seq_pkg::WAKE_HOLD_MS);
	localparam logic [pwr_seq_pkg::MS_W-1:0] SHUT_LEN =
		pwr_seq_pkg::MS_W'(pwr_seq_pkg::SHUTDOWN_MS);
	localparam logic [pwr_seq_pkg::MS_W-1:0] FAST_LEN =
		pwr_seq_pkg::MS_W'(pwr_seq_pkg::FAST_OFF_MAX_MS / 2);
	localparam logic [pwr_seq_pkg::MS_W-1:0] BOOT_LEN =
		pwr_seq_pkg::MS_W'(pwr_seq_pkg::BOOT_MS);
	localparam logic [15:0] TICK_LAST =
		16'(MS_TICKS - 1);

	// Two-stage synchronisers; pins are asynchronous to this clock.
	logic [2:0] sync1_reg;   // First stage, read only by second stage.
	logic [2:0] sync2_reg;   // Second stage: key, fast-off, wake.
	logic [2:0] prev_reg;    // Delayed copy for edge detection.

	// State of the sequencer.
	mod_state_e                  state_reg, state_next;
	logic [15:0]                 tick_reg, tick_next;   // Sub-ms divider.
	logic [pwr_seq_pkg::MS_W-1:0] key_ms_reg, key_ms_next; // Key low time.
	logic [pwr_seq_pkg::MS_W-1:0] wake_ms_reg, wake_ms_next; // Wake high.
	logic [pwr_seq_pkg::MS_W-1:0] tmr_reg, tmr_next;  // Phase timer.
	logic                        wake_arm_reg, wake_arm_next; // Edge seen.
	logic                        fast_en_reg, fast_en_next;   // Fast-off on.
	logic                        status_reg, status_next;     // Status pin.
	logic                        ms_tick;  // One-cycle millisecond pulse.
	logic                        key_low;  // Synchronised key is low.
	logic                        key_rel;  // Key released this cycle.
	logic                        fast_fall;
	logic                        wake_rise;

	assign key_low   = ~sync2_reg[0];
	assign key_rel   = sync2_reg[0] & ~prev_reg[0];
	assign fast_fall = ~sync2_reg[1] & prev_reg[1]; // [RULE11]
	assign wake_rise = sync2_reg[2] & ~prev_reg[2]; // [RULE14]
	assign ms_tick   = (tick_reg == TICK_LAST);

	// Register the synchroniser stages; idle levels follow the pulls.
	always_ff @(posedge i_core_clk)
	begin
		if (!i_reset_n)
		begin
			sync1_reg <= 3'h3;
			sync2_reg <= 3'h3;
			prev_reg  <= 3'h3;
		end
		else
		begin
			sync1_reg <= {pins.psm_wake_pin, pins.fast_off_pin,
				pins.power_key_n};
			sync2_reg <= sync1_reg;
			prev_reg  <= sync2_reg;
		end
	end

	// Next-state logic of the power sequencer.
	always_comb
	begin
		state_next    = state_reg;
		tick_next     = ms_tick ? 16'h0000 : tick_reg + 16'h0001;
		key_ms_next   = key_ms_reg;
		wake_ms_next  = wake_ms_reg;
		tmr_next      = tmr_reg;
		wake_arm_next = wake_arm_reg;
		fast_en_next  = fast_en_reg;
		status_next   = status_reg;
		// Key low time saturates so a stuck key cannot wrap the count.
		if (!key_low)
			key_ms_next = '0;
		else if (ms_tick && key_ms_reg != '1)
			key_ms_next = key_ms_reg + 1'b1;
		// Only a rising edge arms the wake timer; a static high does not.
		if (wake_rise)
		begin
			wake_arm_next = 1'b1; // [RULE13]
			wake_ms_next  = '0;
		end
		else if (!sync2_reg[2])
			wake_arm_next = 1'b0;
		else if (ms_tick && wake_ms_reg != '1)
			wake_ms_next = wake_ms_reg + 1'b1;
		if (ms_tick && tmr_reg != '0)
			tmr_next = tmr_reg - 1'b1;
		if (pins.fast_cfg_command)
			fast_en_next = 1'b1; // [RULE10]
		unique case (state_reg)
			ST_OFF:
			begin
				status_next  = 1'b0;
				fast_en_next = 1'b0; // [RULE10]
				// Power on once the key has been low long enough.
				if (key_ms_reg >= ON_MIN)
				begin
					state_next = ST_BOOT; // [RULE1]
					tmr_next   = BOOT_LEN;
				end
			end
			ST_BOOT:
			begin
				// Wait for release so one press does not also power off.
				if (tmr_reg == '0 && !key_low)
				begin
					state_next  = ST_ON;
					status_next = 1'b1; // [RULE16]
				end
			end
			ST_ON:
			begin
				if (key_ms_reg >= RST_MIN)
				begin
					// Long press is the joined restart line.
					state_next  = ST_OFF; // [RULE12]
					status_next = 1'b0;
				end
				else if (key_rel && key_ms_reg >= OFF_MIN &&
					key_ms_reg <= OFF_MAX)
				begin
					state_next = ST_SHUTDOWN; // [RULE4]
					tmr_next   = SHUT_LEN;
				end
				else if (pins.off_command)
				begin
					state_next = ST_SHUTDOWN; // [RULE5]
					tmr_next   = SHUT_LEN;
				end
				else if (fast_en_reg && fast_fall)
				begin
					state_next = ST_SHUTDOWN; // [RULE9]
					tmr_next   = FAST_LEN;
				end
				else if (i_enter_psm)
					state_next = ST_SLEEP;
			end
			ST_SLEEP:
			begin
				if ((wake_arm_reg && wake_ms_reg >= WAKE_MIN) || key_low ||
					i_tau_expire)
				begin
					state_next    = ST_ON; // [RULE15]
					wake_arm_next = 1'b0;
				end
			end
			ST_SHUTDOWN:
			begin
				// Status stays high until the shutdown has completed.
				if (tmr_reg == '0)
				begin
					state_next  = ST_OFF;
					status_next = 1'b0; // [RULE8]
				end
			end
			// Unused state codes fall back to off, the safest place.
			default:
				state_next = ST_OFF;
		endcase
	end

	// Register the sequencer state.
	always_ff @(posedge i_core_clk)
	begin
		if (!i_reset_n)
		begin
			state_reg    <= ST_OFF;
			tick_reg     <= 16'h0000;
			key_ms_reg   <= '0;
			wake_ms_reg  <= '0;
			tmr_reg      <= '0;
			wake_arm_reg <= 1'b0;
			fast_en_reg  <= 1'b0;
			status_reg   <= 1'b0;
		end
		else
		begin
			state_reg    <= state_next;
			tick_reg     <= tick_next;
			key_ms_reg   <= key_ms_next;
			wake_ms_reg  <= wake_ms_next;
			tmr_reg      <= tmr_next;
			wake_arm_reg <= wake_arm_next;
			fast_en_reg  <= fast_en_next;
			status_reg   <= status_next;
		end
	end

	assign pins.status  = status_reg;
	assign o_deep_sleep = (state_reg == ST_SLEEP);
endmodule : module_power_key_sequencer
`default_nettype wire

//--- rtl/power_key_host.sv
// Purpose: Host end: drives timed pulses on the module control pins.
// Assumes: Status pin is asynchronous and synchronised here.
// Notes:   Key pulses aim at the middle of their window; wake and fast-off pulses last twice the wake hold.
`timescale 1ns/1ps
`default_nettype none
module power_key_host #(
	// Cycles per millisecond tick; a bench may shorten it to save run time.
	parameter int unsigned MS_TICKS = pwr_seq_pkg::MS_CYCLES
) (
	input  wire logic              i_core_clk,  // Core clock.
	input  wire logic              i_reset_n,   // Synchronous reset, low.
	input  wire pwr_seq_pkg::host_cmd_e i_cmd,  // Command, held to accept.
	output logic                   o_ready,     // High when idle.
	output logic                   o_status,    // Synchronised status.
	pwr_seq_if.host                pins         // Control pins.
);
	typedef enum logic [1:0] {H_SETTLE, H_IDLE, H_PULSE} host_state_e;

	localparam logic [15:0] TICK_LAST = 16'(MS_TICKS - 1);
	localparam int W = pwr_seq_pkg::MS_W;

	host_state_e    state_reg, state_next;
	logic [15:0]    tick_reg, tick_next;  // Sub-ms divider.
	logic [W-1:0]   ms_reg, ms_next;      // Pulse time remaining.
	logic           key_reg, key_next;    // Key driven low while high.
	logic           wake_reg, wake_next;  // Wake level.
	logic           foff_reg, foff_next;  // Fast-off driven low.
	logic           offc_reg, offc_next;  // Power-off command strobe.
	logic           cfgc_reg, cfgc_next;  // Fast-off config strobe.
	logic [1:0]     st_sync_reg;          // Status synchroniser.
	logic           ms_tick;

	assign ms_tick = (tick_reg == TICK_LAST);

	// Next values: one pulse at a time, key released at the end.
	always_comb
	begin
		state_next = state_reg;
		tick_next  = ms_tick ? 16'h0000 : tick_reg + 16'h0001; // [RULE17]
		ms_next    = (ms_tick && ms_reg != '0) ? ms_reg - 1'b1 : ms_reg;
		key_next   = key_reg;
		wake_next  = wake_reg;
		foff_next  = foff_reg;
		offc_next  = 1'b0;
		cfgc_next  = 1'b0;
		unique case (state_reg)
			H_SETTLE:
			begin
				// Give the supply time before touching the key.
				if (ms_reg == '0)
					state_next = H_IDLE; // [RULE2]
			end
			H_IDLE:
			begin
				foff_next = 1'b0;
				unique case (i_cmd)
					pwr_seq_pkg::CMD_POWER_ON:
					begin
						key_next = 1'b1; // [RULE1]
						ms_next  = W'(pwr_seq_pkg::ON_MID_MS);
					end
					pwr_seq_pkg::CMD_POWER_OFF:
					begin
						key_next = 1'b1; // [RULE4]
						ms_next  = W'(pwr_seq_pkg::OFF_MID_MS);
					end
					pwr_seq_pkg::CMD_RESET:
					begin
						key_next = 1'b1; // [RULE12]
						ms_next  = W'(pwr_seq_pkg::RST_MID_MS);
					end
					pwr_seq_pkg::CMD_WAKE:
					begin
						wake_next = 1'b1; // [RULE13]
						ms_next   = W'(pwr_seq_pkg::WAKE_MID_MS);
					end
					pwr_seq_pkg::CMD_FAST_OFF:
					begin
						foff_next = 1'b1;
						ms_next   = W'(pwr_seq_pkg::WAKE_MID_MS);
					end
					pwr_seq_pkg::CMD_OFF_COMMAND:
						offc_next = 1'b1; // [RULE6]
					pwr_seq_pkg::CMD_FAST_CFG:
						cfgc_next = 1'b1;
					default:
						ms_next = ms_reg;
				endcase
				if (i_cmd != pwr_seq_pkg::CMD_NONE &&
					i_cmd != pwr_seq_pkg::CMD_OFF_COMMAND &&
					i_cmd != pwr_seq_pkg::CMD_FAST_CFG)
					state_next = H_PULSE;
			end
			H_PULSE:
			begin
				// Always release, so the key is never held low for good.
				if (ms_reg == '0)
				begin
					key_next   = 1'b0; // [RULE3]
					wake_next  = 1'b0;
					foff_next  = 1'b0;
					state_next = H_IDLE;
				end
			end
			// The unused code returns to idle with every pin released.
			default:
			begin
				key_next   = 1'b0;
				wake_next  = 1'b0;
				foff_next  = 1'b0;
				state_next = H_IDLE;
			end
		endcase
	end

	// Register the host state.
	always_ff @(posedge i_core_clk)
	begin
		if (!i_reset_n)
		begin
			state_reg   <= H_SETTLE;
			tick_reg    <= 16'h0000;
			ms_reg      <= W'(pwr_seq_pkg::SUPPLY_WAIT_MS);
			key_reg     <= 1'b0;
			wake_reg    <= 1'b0;
			foff_reg    <= 1'b0;
			offc_reg    <= 1'b0;
			cfgc_reg    <= 1'b0;
			st_sync_reg <= 2'h0;
		end
		else
		begin
			state_reg   <= state_next;
			tick_reg    <= tick_next;
			ms_reg      <= ms_next;
			key_reg     <= key_next;
			wake_reg    <= wake_next;
			foff_reg    <= foff_next;
			offc_reg    <= offc_next;
			cfgc_reg    <= cfgc_next;
			st_sync_reg <= {st_sync_reg[0], pins.status}; // [RULE8]
		end
	end

	assign pins.power_key_n      = ~key_reg;
	assign pins.psm_wake_pin     = wake_reg;
	assign pins.fast_off_pin_o   = 1'b0;
	assign pins.fast_off_pin_oe  = foff_reg;
	assign pins.off_command      = offc_reg;
	assign pins.fast_cfg_command = cfgc_reg;
	assign o_ready  = (state_reg == H_IDLE);
	assign o_status = st_sync_reg[1];
endmodule : power_key_host
`default_nettype wire

//--- rtl/pwr_seq_if.sv
// Purpose: Pin bundle between the host controller and the module.
// Assumes: Both ends share the core clock.
// Notes:   The fast-off pin is pulled up here; the wake pin has no pull and is always host-driven.
`timescale 1ns/1ps
`default_nettype none
interface pwr_seq_if;
	logic power_key_n;       // Power key, low is active, host drives.
	logic fast_off_pin_o;    // Host drive value of fast-off pin.
	logic fast_off_pin_oe;   // Host drives fast-off pin while high.
	logic fast_off_pin;      // Resolved fast-off pin, pulled up.
	logic psm_wake_pin;      // Wake pin, host drives.
	logic status;            // Module status output.
	logic off_command;       // One-cycle power-off command strobe.
	logic fast_cfg_command;  // One-cycle fast-off configuration strobe.
	assign fast_off_pin = fast_off_pin_oe ? fast_off_pin_o : 1'b1;
	modport host (output power_key_n, fast_off_pin_o, fast_off_pin_oe,
		psm_wake_pin, off_command, fast_cfg_command, input status);
	modport device (input power_key_n, fast_off_pin, psm_wake_pin,
		off_command, fast_cfg_command, output status);
endinterface : pwr_seq_if
`default_nettype wire

//--- rtl/pwr_seq_pkg.sv
// Purpose: Shared constants and types for the module power key sequencer.
// Assumes: Core clock of 10 MHz, one millisecond tick derived from it.
// Notes:   All timing figures are in milliseconds unless named otherwise.
package pwr_seq_pkg;
	localparam int unsigned CLK_HZ          = 10000000; // Core clock rate.
	localparam int unsigned MS_CYCLES       = CLK_HZ / 1000; // Cycles per ms.
	localparam int unsigned ON_MIN_MS       = 500;  // Power-on pulse, least.
	localparam int unsigned ON_MAX_MS       = 1000; // Power-on pulse, most.
	localparam int unsigned OFF_MIN_MS      = 650;  // Power-off pulse, least.
	localparam int unsigned OFF_MAX_MS      = 1500; // Power-off pulse, most.
	localparam int unsigned RST_MIN_MS      = 2000; // Reset pulse, least.
	localparam int unsigned RST_MAX_MS      = 3800; // Reset pulse, most.
	localparam int unsigned SUPPLY_WAIT_MS  = 30;   // Supply settle wait.
	localparam int unsigned WAKE_HOLD_MS    = 30;   // Wake level hold, least.
	localparam int unsigned FAST_OFF_MAX_MS = 100;  // Fast-off deadline.
	localparam int unsigned SHUTDOWN_MS     = 50;   // Orderly shutdown time.
	localparam int unsigned BOOT_MS         = 20;   // Boot time to status high.
	localparam int unsigned ON_MID_MS   = (ON_MIN_MS + ON_MAX_MS) / 2;
	localparam int unsigned OFF_MID_MS  = (OFF_MIN_MS + OFF_MAX_MS) / 2;
	localparam int unsigned RST_MID_MS  = (RST_MIN_MS + RST_MAX_MS) / 2;
	localparam int unsigned WAKE_MID_MS = WAKE_HOLD_MS * 2;
	localparam int unsigned MS_W        = 13; // Width of millisecond counters.

	// Host command codes for the host end's user port.
	typedef enum logic [2:0] {
		CMD_NONE, CMD_POWER_ON, CMD_POWER_OFF, CMD_RESET, CMD_WAKE,
		CMD_OFF_COMMAND, CMD_FAST_OFF, CMD_FAST_CFG
	} host_cmd_e;
endpackage : pwr_seq_pkg
